// ==== inc/assf_pkg.sv ====
// Constants and types for the axis sample status flag block
package assf_pkg;
   localparam int AXES = 3;
   localparam int AX_X = 0;
   localparam int AX_Y = 1;
   localparam int AX_Z = 2;

   // Sample status bit positions
   localparam int B_XNEW = 0;
   localparam int B_YNEW = 1;
   localparam int B_ZNEW = 2;
   localparam int B_ANYNEW = 3;
   localparam int B_XOVW = 4;
   localparam int B_YOVW = 5;
   localparam int B_ZOVW = 6;
   localparam int B_ALLOVW = 7;
   localparam int NEW_LSB = 0;
   localparam int OVW_LSB = 4;

   // Wishbone register byte addresses
   localparam logic [7:0] ADR_SAMPLE_STATUS = 8'h00;
   localparam logic [7:0] ADR_MODE = 8'h04;
   localparam logic [7:0] ADR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;

   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [2:0] AXES_NONE = 3'h0;
   localparam logic [2:0] AXES_ALL = 3'h7;

   typedef enum logic [1:0] {
      ASSF_STANDBY = 2'b00,
      ASSF_READY = 2'b01,
      ASSF_ACTIVE = 2'b10
   } assf_mode_t;
endpackage

// ==== src/assf_axis_flags.sv ====
// Per-axis new-sample and overwrite flag pair
`timescale 1ns/1ns
module assf_axis_flags
   import assf_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Events
   input wire logic clear_all_i,
   input wire logic acq_i,
   input wire logic high_read_i,
   // Flags
   output logic new_o,
   output logic ovw_o
);
   logic new_reg;
   logic ovw_reg;

   // Set wins over the read clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all_i) begin
         new_reg <= 1'b0;
      end else if (acq_i) begin
         new_reg <= 1'b1;
      end else if (high_read_i) begin
         new_reg <= 1'b0;
      end
   end

   // A read in the same cycle as the new sample fetched the old one in time
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all_i) begin
         ovw_reg <= 1'b0;
      end else if (acq_i && new_reg && !high_read_i) begin
         ovw_reg <= 1'b1;
      end else if (high_read_i) begin
         ovw_reg <= 1'b0;
      end
   end

   assign new_o = new_reg;
   assign ovw_o = ovw_reg;
endmodule

// ==== src/assf_top.sv ====
// Sample status flags with Wishbone registers and interrupt
`timescale 1ns/1ns
module assf_top
   import assf_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Acquisition completions, one pulse per axis
   input wire logic acq_x_i,
   input wire logic acq_y_i,
   input wire logic acq_z_i,
   // Host reads of each axis high output byte
   input wire logic x_high_read_i,
   input wire logic y_high_read_i,
   input wire logic z_high_read_i,
   // Status
   output logic [7:0] sample_status_o,
   output logic [1:0] mode_o,
   output logic irq_o
);
   logic [2:0] acq_raw;
   logic [2:0] acq;
   logic [2:0] hrd;
   logic [2:0] axis_new;
   logic [2:0] axis_ovw;
   logic req;
   logic wr_stb;
   logic rd_stb;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] rd_mux;
   assf_mode_t mode_reg;
   assf_mode_t mode_next;
   logic mode_wr_ok;
   logic clear_all;
   logic any_new_reg;
   logic all_ovw_reg;
   logic [2:0] fetched_reg;
   logic [2:0] fetched_now;
   logic [2:0] arrived_reg;
   logic [2:0] arrived_now;
   logic all_fetched;
   logic set_complete;
   logic [7:0] flags;
   logic [7:0] flags_prev_reg;
   logic [7:0] rise;
   logic [7:0] irq_stat_reg;
   logic [7:0] irq_mask_reg;

   assign acq_raw = {acq_z_i, acq_y_i, acq_x_i};
   assign hrd = {z_high_read_i, y_high_read_i, x_high_read_i};

   // Samples only complete while the sensor is active
   assign acq = (mode_reg == ASSF_ACTIVE) ? acq_raw : AXES_NONE;

   // Bus decode; one-cycle ack, dropped the cycle after
   assign req = cyc_i && stb_i && !ack_reg;
   assign wr_stb = req && we_i;
   assign rd_stb = req && !we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req;
      end
   end

   // Sample status has no write path at all
   always_comb begin
      rd_mux = 32'h0;
      unique case (adr_i)
         ADR_SAMPLE_STATUS: rd_mux[7:0] = flags;
         ADR_MODE: rd_mux[1:0] = mode_reg;
         ADR_IRQ_STATUS: rd_mux[7:0] = irq_stat_reg;
         ADR_IRQ_MASK: rd_mux[7:0] = irq_mask_reg;
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= 32'h0;
      end else if (rd_stb) begin
         dat_reg <= rd_mux;
      end
   end

   // Mode control; the unused code is refused and the mode kept
   always_comb begin
      mode_next = mode_reg;
      mode_wr_ok = 1'b0;
      if (wr_stb && sel_i[0] && adr_i == ADR_MODE) begin
         unique case (dat_i[1:0])
            ASSF_STANDBY: mode_wr_ok = 1'b1;
            ASSF_READY: mode_wr_ok = 1'b1;
            ASSF_ACTIVE: mode_wr_ok = 1'b1;
            default: mode_wr_ok = 1'b0;
         endcase
         if (mode_wr_ok) begin
            mode_next = assf_mode_t'(dat_i[1:0]);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= ASSF_STANDBY;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Entry into active from standby or ready
   assign clear_all = (mode_next == ASSF_ACTIVE) && (mode_reg != ASSF_ACTIVE);

   // Per-axis flag cells
   assf_axis_flags u_x (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_all_i(clear_all),
      .acq_i(acq[AX_X]),
      .high_read_i(hrd[AX_X]),
      .new_o(axis_new[AX_X]),
      .ovw_o(axis_ovw[AX_X])
   );

   assf_axis_flags u_y (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_all_i(clear_all),
      .acq_i(acq[AX_Y]),
      .high_read_i(hrd[AX_Y]),
      .new_o(axis_new[AX_Y]),
      .ovw_o(axis_ovw[AX_Y])
   );

   assf_axis_flags u_z (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_all_i(clear_all),
      .acq_i(acq[AX_Z]),
      .high_read_i(hrd[AX_Z]),
      .new_o(axis_new[AX_Z]),
      .ovw_o(axis_ovw[AX_Z])
   );

   // High bytes fetched since each axis last delivered a sample
   assign fetched_now = (fetched_reg & ~acq) | hrd;
   assign all_fetched = (fetched_now == AXES_ALL);

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all) begin
         fetched_reg <= AXES_NONE;
      end else if (all_fetched) begin
         fetched_reg <= AXES_NONE;
      end else begin
         fetched_reg <= fetched_now;
      end
   end

   // Combined flag; a fresh sample in the clearing cycle keeps it set
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all) begin
         any_new_reg <= 1'b0;
      end else if (acq != AXES_NONE) begin
         any_new_reg <= 1'b1;
      end else if (all_fetched) begin
         any_new_reg <= 1'b0;
      end
   end

   // Axes delivered toward the next complete set
   assign arrived_now = arrived_reg | acq;
   assign set_complete = (arrived_now == AXES_ALL);

   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all) begin
         arrived_reg <= AXES_NONE;
      end else if (set_complete) begin
         arrived_reg <= AXES_NONE;
      end else begin
         arrived_reg <= arrived_now;
      end
   end

   // Whole set replaced while the earlier one was still unfetched
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_all) begin
         all_ovw_reg <= 1'b0;
      end else if (set_complete && any_new_reg && !all_fetched) begin
         all_ovw_reg <= 1'b1;
      end else if (all_fetched) begin
         all_ovw_reg <= 1'b0;
      end
   end

   // Sample status layout
   always_comb begin
      flags = FLAGS_RESET;
      flags[B_ALLOVW] = all_ovw_reg;
      flags[B_ZOVW] = axis_ovw[AX_Z];
      flags[B_YOVW] = axis_ovw[AX_Y];
      flags[B_XOVW] = axis_ovw[AX_X];
      flags[B_ANYNEW] = any_new_reg;
      flags[B_ZNEW] = axis_new[AX_Z];
      flags[B_YNEW] = axis_new[AX_Y];
      flags[B_XNEW] = axis_new[AX_X];
   end

   // Interrupt events are flag rises
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_prev_reg <= FLAGS_RESET;
      end else begin
         flags_prev_reg <= flags;
      end
   end

   assign rise = flags & ~flags_prev_reg;

   // Write one to clear; a rise in the same cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_reg <= FLAGS_RESET;
      end else if (wr_stb && sel_i[0] && adr_i == ADR_IRQ_STATUS) begin
         irq_stat_reg <= (irq_stat_reg & ~dat_i[7:0]) | rise;
      end else begin
         irq_stat_reg <= irq_stat_reg | rise;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_reg <= MASK_RESET;
      end else if (wr_stb && sel_i[0] && adr_i == ADR_IRQ_MASK) begin
         irq_mask_reg <= dat_i[7:0];
      end
   end

   // Outputs
   assign irq_o = |(irq_stat_reg & irq_mask_reg);
   assign sample_status_o = flags;
   assign mode_o = mode_reg;
   assign dat_o = dat_reg;
   assign ack_o = ack_reg;
endmodule

// ==== verification/assf_host_model.sv ====
// Host model issuing high-byte fetch strobes
`timescale 1ns/1ns
module assf_host_model (
   // Clock
   input wire logic clk_i,
   // Fetch requests, one bit per axis
   input wire logic [2:0] fetch_i,
   // Fetch strobes
   output logic x_high_read_o,
   output logic y_high_read_o,
   output logic z_high_read_o
);
   // Registered, so each strobe follows its fetch request one cycle later and lasts as long as it
   always_ff @(posedge clk_i) begin
      x_high_read_o <= fetch_i[0];
      y_high_read_o <= fetch_i[1];
      z_high_read_o <= fetch_i[2];
   end
endmodule

// ==== verification/assf_top_bench.sv ====
// Self-checking bench for the sample status flags
`timescale 1ns/1ns
module assf_top_bench
   import assf_pkg::*;
;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, xr, yr, zr;
   logic [7:0] adr_i, sample_status_o, m;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o;
   logic [1:0] mode_o;
   logic [2:0] acq, fetch;
   logic [7:0] exp_q[$];
   logic [3:0] sel_v = 4'h1;
   int n_mismatch = 0;
   int tests_run = 0;
   assf_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .acq_x_i(acq[0]), .acq_y_i(acq[1]), .acq_z_i(acq[2]), .x_high_read_i(xr),
      .y_high_read_i(yr), .z_high_read_i(zr), .sample_status_o(sample_status_o),
      .mode_o(mode_o), .irq_o(irq_o));
   assf_host_model host (.clk_i(clk_i), .fetch_i(fetch), .x_high_read_o(xr),
      .y_high_read_o(yr), .z_high_read_o(zr));
   initial begin
      clk_i = 0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Read data compared at the ack edge, oldest note first
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0)
         chk("read data", exp_q.pop_front(), dat_o[7:0]);
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
         input logic [7:0] e);
      int n = 0;
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      sel_i <= sel_v;
      dat_i <= {24'h0, d};
      if (!w) exp_q.push_back(e);
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         tally_and_finish();
      end else begin
         cyc_i <= 0;
         stb_i <= 0;
         @(posedge clk_i);
      end
   endtask
   // Acquisition and fetch strobes, then settle
   task automatic ev(input logic [2:0] a, input logic [2:0] r);
      acq <= a;
      fetch <= r;
      @(posedge clk_i);
      acq <= 3'h0;
      fetch <= 3'h0;
      repeat (4) @(posedge clk_i);
   endtask
   initial begin
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, acq, fetch} = '0;
      rst_i = 1;
      void'($urandom(32'h2774));
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, FLAGS_RESET);
      wb(0, ADR_IRQ_MASK, 8'h00, MASK_RESET);
      wb(0, 8'h10, 8'h00, 8'h00);
      ev(3'h7, 3'h0);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h00);
      wb(1, ADR_MODE, 8'h02, 8'h00);
      wb(1, ADR_MODE, 8'h03, 8'h00);
      wb(0, ADR_MODE, 8'h00, 8'h02);
      wb(1, ADR_IRQ_STATUS, 8'hff, 8'h00);
      wb(1, ADR_IRQ_MASK, 8'h01, 8'h00);
      ev(3'h7, 3'h0);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h0f);
      chk("irq", 8'h01, {7'h0, irq_o});
      chk("status pins", 8'h0f, sample_status_o);
      chk("mode pins", {6'h0, ASSF_ACTIVE}, {6'h0, mode_o});
      ev(3'h7, 3'h0);
      wb(1, ADR_SAMPLE_STATUS, 8'h00, 8'h00);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'hff);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'hff);
      ev(3'h0, 3'h1);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'hee);
      ev(3'h0, 3'h6);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h00);
      wb(1, ADR_IRQ_STATUS, 8'hff, 8'h00);
      chk("irq", 8'h00, {7'h0, irq_o});
      // Low lane deselected: the write must be ignored
      sel_v = 4'he;
      wb(1, ADR_IRQ_MASK, 8'hff, 8'h00);
      sel_v = 4'h1;
      wb(0, ADR_IRQ_MASK, 8'h00, 8'h01);
      for (int i = 0; i < 8; i++) begin
         m = 8'($urandom_range(1, 7));
         ev(m[2:0], 3'h0);
         wb(1, ADR_SAMPLE_STATUS, 8'($urandom), 8'h00);
         wb(0, ADR_SAMPLE_STATUS, 8'h00, m | 8'h08);
         ev(3'h0, 3'h7);
         wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h00);
      end
      ev(3'h7, 3'h0);
      wb(1, ADR_MODE, 8'h00, 8'h00);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h0f);
      wb(1, ADR_MODE, 8'h02, 8'h00);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h00);
      // Active to active keeps flags; ready to active clears them
      ev(3'h7, 3'h0);
      wb(1, ADR_MODE, 8'h02, 8'h00);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h0f);
      wb(1, ADR_MODE, 8'h01, 8'h00);
      wb(0, ADR_MODE, 8'h00, 8'h01);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h0f);
      wb(1, ADR_MODE, 8'h02, 8'h00);
      wb(0, ADR_SAMPLE_STATUS, 8'h00, 8'h00);
      repeat (4) @(posedge clk_i);
      tally_and_finish();
   end
endmodule

// ==== verification/assf_top_sva.sv ====
// Checker for the sample status flags
`timescale 1ns/1ns
module assf_top_sva
   import assf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic acq_x_i,
   input wire logic acq_y_i,
   input wire logic acq_z_i,
   input wire logic x_high_read_i,
   input wire logic y_high_read_i,
   input wire logic z_high_read_i,
   input wire logic [7:0] sample_status_o,
   input wire logic [1:0] mode_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic act;
   assign act = (mode_o == ASSF_ACTIVE);
   chk_x_new_set: assert property (
      acq_x_i && act |=> sample_status_o[B_XNEW]) else $error("x new not set");
   chk_y_new_set: assert property (
      acq_y_i && act |=> sample_status_o[B_YNEW]) else $error("y new not set");
   chk_z_new_set: assert property (
      acq_z_i && act |=> sample_status_o[B_ZNEW]) else $error("z new not set");
   chk_any_new_set: assert property (
      (acq_x_i || acq_y_i || acq_z_i) && act |=> sample_status_o[B_ANYNEW])
      else $error("any new not set");
   chk_x_ovw_set: assert property (
      acq_x_i && act && sample_status_o[B_XNEW] && !x_high_read_i |=> sample_status_o[B_XOVW])
      else $error("x overwrite not set");
   chk_y_ovw_set: assert property (
      acq_y_i && act && sample_status_o[B_YNEW] && !y_high_read_i |=> sample_status_o[B_YOVW])
      else $error("y overwrite not set");
   chk_z_ovw_set: assert property (
      acq_z_i && act && sample_status_o[B_ZNEW] && !z_high_read_i |=> sample_status_o[B_ZOVW])
      else $error("z overwrite not set");
   chk_ovw_read_clr: assert property (
      x_high_read_i |=> !sample_status_o[B_XOVW]) else $error("x overwrite kept");
   chk_y_ovw_clr: assert property (
      y_high_read_i |=> !sample_status_o[B_YOVW]) else $error("y overwrite kept");
   chk_z_ovw_clr: assert property (
      z_high_read_i |=> !sample_status_o[B_ZOVW]) else $error("z overwrite kept");
   chk_x_new_clr: assert property (
      x_high_read_i && !(acq_x_i && act) |=> !sample_status_o[B_XNEW])
      else $error("x new kept after read");
   chk_y_new_clr: assert property (
      y_high_read_i && !(acq_y_i && act) |=> !sample_status_o[B_YNEW])
      else $error("y new kept after read");
   chk_z_new_clr: assert property (
      z_high_read_i && !(acq_z_i && act) |=> !sample_status_o[B_ZNEW])
      else $error("z new kept after read");
   chk_active_entry: assert property (
      $rose(act) |-> sample_status_o == FLAGS_RESET) else $error("flags not cleared");
endmodule
bind assf_top assf_top_sva chk (.clk_i(clk_i), .rst_i(rst_i), .acq_x_i(acq_x_i),
   .acq_y_i(acq_y_i), .acq_z_i(acq_z_i), .x_high_read_i(x_high_read_i),
   .y_high_read_i(y_high_read_i), .z_high_read_i(z_high_read_i),
   .sample_status_o(sample_status_o), .mode_o(mode_o));
